// ### fan_cfg_pkg.sv
// package: register map, field layout, reset values and state types of the fan configuration bank
package fan_cfg_pkg;
	// register offsets
	localparam logic [7:0] OFS_SMOOTH_VCORE = 8'h10;
	localparam logic [7:0] OFS_R2_OFFSET = 8'h72;
	localparam logic [7:0] OFS_CFG2 = 8'h73;
	localparam logic [7:0] OFS_MASK1 = 8'h74;
	localparam logic [7:0] OFS_MASK2 = 8'h75;
	localparam logic [7:0] OFS_VOLT_LSB = 8'h76;
	localparam logic [7:0] OFS_TEMP_LSB = 8'h77;
	localparam logic [7:0] OFS_CFG3 = 8'h78;
	localparam logic [7:0] OFS_TMR_STATUS = 8'h79;
	localparam logic [7:0] OFS_TMR_LIMIT = 8'h7a;
	localparam logic [7:0] OFS_PULSES = 8'h7b;
	localparam logic [7:0] OFS_CFG5 = 8'h7c;
	localparam logic [7:0] OFS_CFG4 = 8'h7d;
	localparam logic [7:0] OFS_TEST1 = 8'h7e;
	localparam logic [7:0] OFS_TEST2 = 8'h7f;
	// reading registers held while extended bits are pending
	localparam logic [7:0] OFS_CORE_V_MSB = 8'h21;
	localparam logic [7:0] OFS_SUPPLY_V_MSB = 8'h22;
	localparam logic [7:0] OFS_TEMP_MSB_FIRST = 8'h25;
	// reset values
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_PULSES = 8'h55;
	localparam logic [7:0] RST_CFG5 = 8'h01;
	// smoothing/core voltage register fields, then the config five format bit
	localparam int BIT_SLOW_R1 = 0;
	localparam int BIT_SLOW_LOCAL = 1;
	localparam int BIT_SLOW_R2 = 2;
	localparam int BIT_THERMAL_LIMIT_PIN_MANUAL = 3;
	localparam int BIT_VCORE_LOW = 6;
	localparam int BIT_EXTRA_SLOW = 7;
	localparam logic [7:0] SMOOTH_WR_MASK = 8'hcf; // bits 5:4 reserved
	localparam int BIT_SIGNED_FMT = 0;
	// slow multiplies by four; extra stretch adds 401/1024 (about 39.2 percent)
	localparam int SLOW_SHIFT = 2;
	localparam int EXTRA_NUM = 401;
	localparam int EXTRA_SHIFT = 10;
	localparam int NUM_FANS = 3;
	// core voltage supervision
	typedef enum logic [1:0] {
		vc_normal = 2'b00,
		vc_low = 2'b01,
		vc_spinup = 2'b11
	} vcore_state_e;
	// register access request from the bus protocol engine
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_s;
	// supervision events towards status and alert logic
	typedef struct packed {
		logic status_set;
		logic alert;
		logic processor_hot_input_en;
		logic spinup_start;
	} vcore_evt_s;
endpackage : fan_cfg_pkg

// ### fan_cfg_regs.sv
// module: fan smoothing, thermal pin and core voltage configuration register bank
// Function
// - slow remote-one bit: fan one smoothing x4
// - slow local bit: fan two smoothing x4
// - slow remote-two bit: fan three smoothing x4
// - extra stretch adds 39.2 percent everywhere
// - thermal pin stays active in manual only with bit three set
// - thermal event overrides fan setting, except manual mode with bit three clear
// - core low on standby: status, alert, hot-off
// - core recovered: hot monitor on, spin-up
// - smoothing config register resets to zero
// - lock bit makes lockable registers read-only
// - extended reads first freeze msb readings
// - config five bit zero picks format
module fan_cfg_regs
	import fan_cfg_pkg::*;
#(
	parameter int TIME_W = 16
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire reg_req_s i_req,
	output logic [7:0] o_reg_rdata,
	input wire logic i_lock,
	input wire logic [7:0] i_volt_lsb,
	input wire logic [7:0] i_temp_lsb,
	input wire logic [7:0] i_tmr_status,
	input wire logic [NUM_FANS*TIME_W-1:0] i_smooth_time,
	output logic [NUM_FANS*(TIME_W+3)-1:0] o_smooth_time,
	input wire logic i_thermal_limit_pin_n,
	input wire logic i_manual_mode,
	output logic o_fans_full_on,
	input wire logic i_on_standby,
	input wire logic i_core_voltage_below_low,
	input wire logic i_alert_enable,
	input wire logic i_spinup_done,
	output vcore_evt_s o_vcore_evt,
	output logic o_signed_temp_format,
	output logic o_freeze_voltage,
	output logic o_freeze_temp,
	output logic [7:0] o_cfg2,
	output logic [7:0] o_mask1,
	output logic [7:0] o_mask2,
	output logic [7:0] o_cfg3,
	output logic [7:0] o_tmr_limit,
	output logic [7:0] o_pulses_per_rev,
	output logic [7:0] o_cfg4,
	output logic [7:0] o_r2_offset
);

	typedef struct packed {
		logic [7:0] smooth_vcore;
		logic [7:0] r2_offset;
		logic [7:0] cfg2;
		logic [7:0] mask1;
		logic [7:0] mask2;
		logic [7:0] volt_lsb;
		logic [7:0] temp_lsb;
		logic [7:0] cfg3;
		logic [7:0] tmr_limit;
		logic [7:0] pulses;
		logic [7:0] cfg5;
		logic [7:0] cfg4;
		logic [7:0] rdata;
		logic [1:0] volt_pending; // msb readings still to be read
		logic [2:0] temp_pending;
		logic [2:0] sync_a; // first synchroniser stage
		logic [2:0] sync_b; // thermal_n, standby, core below
		vcore_state_e vstate;
		vcore_evt_s evt;
		logic full_on;
		logic [NUM_FANS*(TIME_W+3)-1:0] smooth;
	} state_s;

	state_s cur;
	state_s next_cur;

	logic thermal_asserted;
	logic core_low_now;
	logic [NUM_FANS-1:0] slow_bits;
	logic wr_open;
	logic wr_lockable;
	logic [NUM_FANS*(TIME_W+3)-1:0] smooth_calc; // scaled times ahead of the state register

	// pin levels after two flip-flops
	assign thermal_asserted = !cur.sync_b[0];
	assign core_low_now = cur.sync_b[1] && cur.sync_b[2];
	assign slow_bits = {cur.smooth_vcore[BIT_SLOW_R2], cur.smooth_vcore[BIT_SLOW_LOCAL],
		cur.smooth_vcore[BIT_SLOW_R1]};
	assign wr_open = i_req.wr;
	assign wr_lockable = i_req.wr && !i_lock;

	// smoothing time scaling per fan
	genvar g;
	generate
		for (g = 0; g < NUM_FANS; g++) begin : g_smooth
			logic [TIME_W+2:0] base;
			logic [TIME_W+2:0] slowed;
			logic [TIME_W+2+EXTRA_SHIFT:0] prod;
			logic [TIME_W+2:0] stretched;
			assign base = {3'h0, i_smooth_time[g*TIME_W +: TIME_W]};
			assign slowed = slow_bits[g] ? (base << SLOW_SHIFT) : base;
			assign prod = {{EXTRA_SHIFT{1'b0}}, slowed} * (TIME_W+3+EXTRA_SHIFT)'(EXTRA_NUM);
			assign stretched = slowed + prod[TIME_W+2+EXTRA_SHIFT:EXTRA_SHIFT];
			assign smooth_calc[g*(TIME_W+3) +: TIME_W+3] =
				cur.smooth_vcore[BIT_EXTRA_SLOW] ? stretched : slowed;
		end
	endgenerate

	// register writes, reads, freeze tracking and supervision
	always_comb begin
		next_cur.smooth_vcore = cur.smooth_vcore;
		next_cur.r2_offset = cur.r2_offset;
		next_cur.cfg2 = cur.cfg2;
		next_cur.mask1 = cur.mask1;
		next_cur.mask2 = cur.mask2;
		next_cur.cfg3 = cur.cfg3;
		next_cur.tmr_limit = cur.tmr_limit;
		next_cur.pulses = cur.pulses;
		next_cur.cfg5 = cur.cfg5;
		next_cur.cfg4 = cur.cfg4;
		next_cur.rdata = cur.rdata;
		next_cur.volt_pending = cur.volt_pending;
		next_cur.temp_pending = cur.temp_pending;
		next_cur.sync_a = {i_core_voltage_below_low, i_on_standby, i_thermal_limit_pin_n};
		next_cur.sync_b = cur.sync_a;
		next_cur.vstate = cur.vstate;
		next_cur.evt = '0;
		next_cur.evt.processor_hot_input_en = 1'b1;
		// one driver for the whole next state: the scaled times enter here
		next_cur.smooth = smooth_calc;
		// live low bits follow the measurement until frozen
		next_cur.volt_lsb = (cur.volt_pending != 2'h0) ? cur.volt_lsb : i_volt_lsb;
		next_cur.temp_lsb = (cur.temp_pending != 3'h0) ? cur.temp_lsb : i_temp_lsb;
		// host writes
		if (wr_lockable) begin
			unique case (i_req.addr)
				OFS_SMOOTH_VCORE: next_cur.smooth_vcore = i_req.wdata & SMOOTH_WR_MASK;
				OFS_R2_OFFSET: next_cur.r2_offset = i_req.wdata;
				OFS_CFG2: next_cur.cfg2 = i_req.wdata;
				OFS_CFG3: next_cur.cfg3 = i_req.wdata;
				OFS_CFG5: next_cur.cfg5 = i_req.wdata;
				OFS_CFG4: next_cur.cfg4 = i_req.wdata;
				default: ;
			endcase
		end
		if (wr_open) begin
			unique case (i_req.addr)
				OFS_MASK1: next_cur.mask1 = i_req.wdata;
				OFS_MASK2: next_cur.mask2 = i_req.wdata;
				OFS_TMR_LIMIT: next_cur.tmr_limit = i_req.wdata;
				OFS_PULSES: next_cur.pulses = i_req.wdata;
				default: ;
			endcase
		end
		// host reads
		if (i_req.rd) begin
			unique case (i_req.addr)
				OFS_SMOOTH_VCORE: next_cur.rdata = cur.smooth_vcore;
				OFS_R2_OFFSET: next_cur.rdata = cur.r2_offset;
				OFS_CFG2: next_cur.rdata = cur.cfg2;
				OFS_MASK1: next_cur.rdata = cur.mask1;
				OFS_MASK2: next_cur.rdata = cur.mask2;
				OFS_VOLT_LSB: next_cur.rdata = cur.volt_lsb;
				OFS_TEMP_LSB: next_cur.rdata = cur.temp_lsb;
				OFS_CFG3: next_cur.rdata = cur.cfg3;
				OFS_TMR_STATUS: next_cur.rdata = i_tmr_status;
				OFS_TMR_LIMIT: next_cur.rdata = cur.tmr_limit;
				OFS_PULSES: next_cur.rdata = cur.pulses;
				OFS_CFG5: next_cur.rdata = cur.cfg5;
				OFS_CFG4: next_cur.rdata = cur.cfg4;
				default: next_cur.rdata = RST_ZERO; // test and foreign offsets
			endcase
			// extended read arms the freeze; each msb read releases its share
			if (i_req.addr == OFS_VOLT_LSB) begin
				next_cur.volt_pending = 2'h3;
			end
			if (i_req.addr == OFS_TEMP_LSB) begin
				next_cur.temp_pending = 3'h7;
			end
			if (i_req.addr == OFS_CORE_V_MSB) begin
				next_cur.volt_pending[0] = 1'b0;
			end
			if (i_req.addr == OFS_SUPPLY_V_MSB) begin
				next_cur.volt_pending[1] = 1'b0;
			end
			for (int i = 0; i < 3; i++) begin
				if (i_req.addr == OFS_TEMP_MSB_FIRST + 8'(i)) begin
					next_cur.temp_pending[i] = 1'b0;
				end
			end
		end
		// thermal pin forces fans regardless of their setting, except in manual mode with bit three clear
		next_cur.full_on = thermal_asserted &&
			(!i_manual_mode || cur.smooth_vcore[BIT_THERMAL_LIMIT_PIN_MANUAL]);
		// core voltage supervision
		unique case (cur.vstate)
			vc_normal: begin
				if (cur.smooth_vcore[BIT_VCORE_LOW] && core_low_now) begin
					next_cur.vstate = vc_low;
					next_cur.evt.status_set = 1'b1;
					next_cur.evt.alert = i_alert_enable;
					next_cur.evt.processor_hot_input_en = 1'b0;
				end
			end
			vc_low: begin
				next_cur.evt.processor_hot_input_en = 1'b0;
				if (!cur.sync_b[2]) begin
					next_cur.vstate = vc_spinup;
					next_cur.evt.processor_hot_input_en = 1'b1;
					next_cur.evt.spinup_start = 1'b1;
				end
			end
			vc_spinup: begin
				if (i_spinup_done) begin
					next_cur.vstate = vc_normal;
				end
			end
			default: next_cur.vstate = vc_normal;
		endcase
	end

	// state register with power-on defaults
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			cur <= '0;
			cur.smooth_vcore <= RST_ZERO;
			cur.pulses <= RST_PULSES;
			cur.cfg5 <= RST_CFG5;
			cur.sync_a <= 3'h1; // thermal pin idle high
			cur.sync_b <= 3'h1;
			cur.vstate <= vc_normal;
			cur.evt.processor_hot_input_en <= 1'b1;
		end else begin
			cur <= next_cur;
		end
	end

	// outputs straight from the state register
	assign o_reg_rdata = cur.rdata;
	assign o_smooth_time = cur.smooth;
	assign o_fans_full_on = cur.full_on;
	assign o_vcore_evt = cur.evt;
	assign o_signed_temp_format = cur.cfg5[BIT_SIGNED_FMT];
	assign o_freeze_voltage = cur.volt_pending != 2'h0;
	assign o_freeze_temp = cur.temp_pending != 3'h0;
	assign o_cfg2 = cur.cfg2;
	assign o_mask1 = cur.mask1;
	assign o_mask2 = cur.mask2;
	assign o_cfg3 = cur.cfg3;
	assign o_tmr_limit = cur.tmr_limit;
	assign o_pulses_per_rev = cur.pulses;
	assign o_cfg4 = cur.cfg4;
	assign o_r2_offset = cur.r2_offset;

endmodule : fan_cfg_regs

// ### host_model.sv
// host model: register requests of the bus protocol engine
module host_model
	import fan_cfg_pkg::*;
(
	input wire logic i_clk,
	output reg_req_s o_req
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle until the first request
	initial o_req = '0;
	// one-cycle request, then one idle cycle
	task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		o_req <= '{w, !w, a, (a == OFS_SMOOTH_VCORE) ? (d & SMOOTH_WR_MASK) : d};
		@(posedge i_clk);
		o_req <= '0;
	endtask : access
endmodule : host_model

// ### fan_cfg_sva.sv
// checker: port-level properties of the fan configuration bank
module fan_cfg_sva
	import fan_cfg_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset,
	input wire reg_req_s i_req,
	input wire logic [7:0] o_reg_rdata,
	input wire logic i_lock,
	input wire logic i_thermal_limit_pin_n,
	input wire logic i_manual_mode,
	input wire logic o_fans_full_on,
	input wire vcore_evt_s o_vcore_evt,
	input wire logic o_signed_temp_format,
	input wire logic o_freeze_voltage,
	input wire logic [7:0] o_cfg2,
	input wire logic [7:0] o_pulses_per_rev
);
	// single clock domain
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	pulses_write_a: assert property (i_req.wr && i_req.addr == OFS_PULSES |=> o_pulses_per_rev == $past(i_req.wdata))
		else $error("pulses write lost");
	read_back_a: assert property (i_req.rd && !i_req.wr && i_req.addr == OFS_PULSES |=> o_reg_rdata == $past(o_pulses_per_rev))
		else $error("pulses read wrong");
	lock_hold_a: assert property (i_req.wr && i_lock && i_req.addr == OFS_CFG2 |=> $stable(o_cfg2))
		else $error("locked write taken");
	fmt_write_a: assert property (i_req.wr && !i_lock && i_req.addr == OFS_CFG5 |=>
		o_signed_temp_format == $past(i_req.wdata[BIT_SIGNED_FMT])) else $error("format bit wrong");
	reserved_read_a: assert property (i_req.rd && i_req.addr == OFS_SMOOTH_VCORE |=> o_reg_rdata[5:4] == 2'b00)
		else $error("reserved bits set");
	volt_freeze_a: assert property (i_req.rd && i_req.addr == OFS_VOLT_LSB |=> o_freeze_voltage)
		else $error("no voltage freeze");
	low_hot_a: assert property (o_vcore_evt.status_set |-> ##[0:1] !o_vcore_evt.processor_hot_input_en)
		else $error("hot monitor kept");
	recover_hot_a: assert property (o_vcore_evt.spinup_start |-> ##[0:1] o_vcore_evt.processor_hot_input_en)
		else $error("hot monitor off");
	thermal_limit_pin_on_a: assert property ((!i_thermal_limit_pin_n && !i_manual_mode)[*5] |-> o_fans_full_on)
		else $error("thermal not forced");
	thermal_limit_pin_off_a: assert property ((i_thermal_limit_pin_n)[*5] |-> !o_fans_full_on)
		else $error("full on stuck");
endmodule : fan_cfg_sva
bind fan_cfg_regs fan_cfg_sva chk (.*);

// ### tb.sv
// testbench: host sequences against a behavioural model of the bank
module tb;
	import fan_cfg_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk = 1'b0, i_reset = 1'b1, i_lock = 1'b0, i_thermal_limit_pin_n = 1'b1, i_manual_mode = 1'b0;
	logic i_on_standby = 1'b0, i_core_voltage_below_low = 1'b0, i_alert_enable = 1'b0, i_spinup_done = 1'b0;
	logic [7:0] i_volt_lsb = 8'h00, i_temp_lsb = 8'h00, i_tmr_status = 8'h00, rnd = 8'h56;
	logic [47:0] i_smooth_time = '0;
	logic [56:0] o_smooth_time;
	logic [7:0] o_reg_rdata, o_cfg2, o_mask1, o_mask2, o_cfg3, o_tmr_limit, o_pulses_per_rev, o_cfg4, o_r2_offset;
	logic o_fans_full_on, o_signed_temp_format, o_freeze_voltage, o_freeze_temp;
	vcore_evt_s o_vcore_evt;
	reg_req_s i_req;
	int err_total = 0, comparisons = 0, shadow[256];
	logic [7:0] slow[6] = '{8'h01, 8'h02, 8'h04, 8'h80, 8'h87, 8'h00};
	host_model host (.i_clk(i_clk), .o_req(i_req));
	fan_cfg_regs uut (.*);
	// 25 MHz clock
	always #20 i_clk = ~i_clk;
	function automatic logic [7:0] lfsr();
		rnd = {rnd[6:0], rnd[7] ^ rnd[5] ^ rnd[4] ^ rnd[3]};
		return rnd;
	endfunction : lfsr
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask : chk
	// write and update the model where the bank accepts it
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host.access(1'b1, a, d);
		if (a inside {8'h10, [8'h72:8'h75], 8'h78, [8'h7a:8'h7d]} &&
			!(i_lock && a inside {8'h10, 8'h72, 8'h73, 8'h78, 8'h7c, 8'h7d}))
			shadow[a] = d & ((a == 8'h10) ? 8'hcf : 8'hff);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		host.access(1'b0, a, 8'h00);
		#1 chk("rdata", shadow[a], o_reg_rdata);
	endtask : rd
	task automatic finish_test();
		if (err_total == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : finish_test
	// cut a hang short
	initial begin
		#400000;
		err_total++;
		finish_test();
	end
	// main sequence
	initial begin
		longint t;
		int n;
		foreach (shadow[k]) shadow[k] = 0;
		shadow[8'h7b] = 8'h55;
		shadow[8'h7c] = 8'h01;
		repeat (20) @(posedge i_clk);
		i_reset <= 1'b0;
		rd(8'h10);
		for (int a = 8'h50; a < 8'h80; a++) if (a > 8'h6f || a == 8'h50) rd(a);
		chk("freeze", 2'b11, {o_freeze_voltage, o_freeze_temp});
		for (int k = 0; k < 7; k++) if (k < 2 || k > 3) host.access(1'b0, 8'h21 + 8'(k), 8'h00);
		#1 chk("freeze", 2'b00, {o_freeze_voltage, o_freeze_temp});
		@(posedge i_clk);
		i_volt_lsb <= lfsr();
		i_temp_lsb <= lfsr();
		i_tmr_status <= lfsr();
		// open writes, then locked writes
		for (int l = 0; l < 2; l++) begin
			@(posedge i_clk);
			i_lock <= l[0];
			for (int a = 8'h70; a < 8'h80; a++) wr(a, lfsr());
			shadow[8'h76] = i_volt_lsb;
			shadow[8'h77] = i_temp_lsb;
			shadow[8'h79] = i_tmr_status;
			rd(8'h10);
			for (int a = 8'h70; a < 8'h80; a++) rd(a);
			chk("format", shadow[8'h7c] & 1, o_signed_temp_format);
			chk("regs", {8'(shadow[8'h72]), 8'(shadow[8'h73]), 8'(shadow[8'h74]), 8'(shadow[8'h75]),
				8'(shadow[8'h78]), 8'(shadow[8'h7a]), 8'(shadow[8'h7b]), 8'(shadow[8'h7d])},
				{o_r2_offset, o_cfg2, o_mask1, o_mask2, o_cfg3, o_tmr_limit, o_pulses_per_rev, o_cfg4});
		end
		@(posedge i_clk);
		i_lock <= 1'b0;
		// smoothing scale per fan
		foreach (slow[k]) begin
			wr(8'h10, slow[k]);
			i_smooth_time <= {lfsr(), lfsr(), lfsr(), lfsr(), lfsr(), lfsr()};
			@(posedge i_clk) #1;
			for (int f = 0; f < 3; f++) begin
				t = i_smooth_time[16*f +: 16];
				if (slow[k][f]) t = t * 4;
				if (slow[k][7]) t = t + (t * 401) / 1024;
				chk("smooth", t, o_smooth_time[19*f +: 19]);
			end
		end
		// thermal pin against manual mode and bit three
		for (int m = 0; m < 4; m++) begin
			wr(8'h10, m[1] ? 8'h08 : 8'h00);
			i_manual_mode <= m[0];
			i_thermal_limit_pin_n <= 1'b0;
			repeat (5) @(posedge i_clk);
			#1 chk("full_on", !m[0] || m[1], o_fans_full_on);
			@(posedge i_clk);
			i_thermal_limit_pin_n <= 1'b1;
			repeat (5) @(posedge i_clk);
		end
		// core voltage low on standby, then recovery
		wr(8'h10, 8'h40);
		for (int e = 0; e < 2; e++) begin
			i_alert_enable <= e[0];
			i_on_standby <= 1'b1;
			i_core_voltage_below_low <= 1'b1;
			for (n = 0; n < 20 && o_vcore_evt.status_set !== 1'b1; n++) @(posedge i_clk) #1;
			chk("status", 2'b10 | e, {o_vcore_evt.status_set, o_vcore_evt.alert});
			@(posedge i_clk) #1 chk("hot_en", 0, o_vcore_evt.processor_hot_input_en);
			@(posedge i_clk);
			i_core_voltage_below_low <= 1'b0;
			for (n = 0; n < 20 && o_vcore_evt.spinup_start !== 1'b1; n++) @(posedge i_clk) #1;
			chk("spinup", 1, o_vcore_evt.spinup_start);
			@(posedge i_clk) #1 chk("hot_en", 1, o_vcore_evt.processor_hot_input_en);
			@(posedge i_clk);
			i_spinup_done <= 1'b1;
			@(posedge i_clk);
			i_spinup_done <= 1'b0;
			repeat (3) @(posedge i_clk);
		end
		finish_test();
	end
endmodule : tb
